// ===== hw/rtcl_pkg.sv
// package: register map, field positions and reset values of the rtc core
package rtcl_pkg;

  // ----------------------------------------------------------------
  // register offsets (byte addresses)
  // ----------------------------------------------------------------
  localparam logic [7:0] OFS_TSR = 8'h00;
  localparam logic [7:0] OFS_TPR = 8'h04;
  localparam logic [7:0] OFS_TAR = 8'h08;
  localparam logic [7:0] OFS_TCR = 8'h0C;
  localparam logic [7:0] OFS_CR  = 8'h10;
  localparam logic [7:0] OFS_SR  = 8'h14;
  localparam logic [7:0] OFS_LR  = 8'h18;
  localparam logic [7:0] OFS_IER = 8'h1C;

  // ----------------------------------------------------------------
  // control register fields
  // ----------------------------------------------------------------
  localparam int CR_LOAD_LSB = 10;
  localparam int CR_LOAD_W   = 4;
  localparam int CR_CLKO     = 9;
  localparam int CR_OSCE     = 8;
  localparam int CR_WPS      = 4;
  localparam int CR_UM       = 3;
  localparam int CR_SUP      = 2;
  localparam int CR_WPE      = 1;
  localparam int CR_SWR      = 0;

  // ----------------------------------------------------------------
  // status, lock and interrupt enable fields
  // ----------------------------------------------------------------
  localparam int SR_TCE  = 4;
  localparam int SR_TAF  = 2;
  localparam int SR_TOF  = 1;
  localparam int SR_TIF  = 0;
  localparam int LR_ONE7 = 7;
  localparam int LR_LRL  = 6;
  localparam int LR_SRL  = 5;
  localparam int LR_CRL  = 4;
  localparam int LR_TCL  = 3;
  localparam int LR_ONES_W = 3;
  localparam int IER_WAKE_PIN_FORCE_ON = 7;
  localparam int IER_SECONDS_PULSE_IRQ_EN = 4;
  localparam int IER_RSV3 = 3;
  localparam int IER_ALARM_IRQ_EN = 2;
  localparam int IER_OVERFLOW_IRQ_EN = 1;
  localparam int IER_INVALID_IRQ_EN = 0;

  // ----------------------------------------------------------------
  // reset values and counter geometry
  // ----------------------------------------------------------------
  localparam logic [31:0] IER_RESET = 32'h0000000F;
  localparam logic        LOCK_RESET = 1'b1;
  localparam int          TPR_W      = 16;
  localparam int          TPR_SEC_BIT = 14;
  localparam logic [31:0] TSR_MAX    = 32'hFFFFFFFF;

endpackage : rtcl_pkg

// ===== hw/rtcl_osc_sync.sv
// oscillator input synchroniser with debounced level and rising tick
`timescale 1ns/100ps
`default_nettype none
module rtcl_osc_sync (
  input  wire logic clk_sys,
  input  wire logic resetn,
  input  wire logic osc_pin,
  output logic      osc_level,
  output logic      osc_tick
);

  logic s1_q, s2_q, s3_q;
  logic lvl_q, lvl_d;
  logic tick_q, tick_d;

  // ----------------------------------------------------------------
  // level accepted only once stages two and three agree
  // ----------------------------------------------------------------
  always_comb begin
    lvl_d  = lvl_q;
    tick_d = 1'b0;
    if (s2_q == s3_q && s3_q != lvl_q) begin
      lvl_d  = s3_q;
      tick_d = s3_q; // rising edge only
    end
  end

  // stage one feeds stage two and nothing else
  always_ff @(posedge clk_sys or negedge resetn) begin
    if (!resetn) begin
      s1_q   <= 1'b0;
      s2_q   <= 1'b0;
      s3_q   <= 1'b0;
      lvl_q  <= 1'b0;
      tick_q <= 1'b0;
    end else begin
      s1_q   <= osc_pin;
      s2_q   <= s1_q;
      s3_q   <= s2_q;
      lvl_q  <= lvl_d;
      tick_q <= tick_d;
    end
  end

  assign osc_level = lvl_q;
  assign osc_tick  = tick_q;

endmodule : rtcl_osc_sync
`default_nettype wire

// ===== hw/rtcl_wake_pin.sv
// open-drain active-low wakeup pin driver
`timescale 1ns/100ps
`default_nettype none
module rtcl_wake_pin (
  input  wire logic clk_sys,
  input  wire logic resetn,
  input  wire logic pin_enable,
  input  wire logic force_on,
  input  wire logic irq_level,
  input  wire logic clk_mode,
  input  wire logic osc_level,
  output logic      pin_o,
  output logic      pin_oe_n
);

  logic drive_q, drive_d;

  // ----------------------------------------------------------------
  // pull low on interrupt or force, or mirror the 32 kHz clock
  // ----------------------------------------------------------------
  always_comb begin
    drive_d = 1'b0;
    if (pin_enable) begin
      if (clk_mode) begin
        drive_d = !osc_level;
      end else begin
        drive_d = irq_level | force_on;
      end
    end
  end

  always_ff @(posedge clk_sys or negedge resetn) begin
    if (!resetn) begin
      drive_q <= 1'b0;
    end else begin
      drive_q <= drive_d;
    end
  end

  // open drain: only ever drives zero, oe_n low while driving
  assign pin_o    = 1'b0;
  assign pin_oe_n = !drive_q;

endmodule : rtcl_wake_pin
`default_nettype wire

// ===== hw/rtcl_core.sv
// rtc core: seconds counter, prescaler, locks, enables and register port
`timescale 1ns/100ps
`default_nettype none
module rtcl_core
  import rtcl_pkg::*;
#(
  parameter int ADDR_W = 8
) (
  input  wire logic              clk_sys,
  input  wire logic              resetn,
  input  wire logic [ADDR_W-1:0] reg_addr,
  input  wire logic [31:0]       reg_wdata,
  input  wire logic              reg_wr,
  input  wire logic              reg_rd,
  input  wire logic              reg_wr_supervisor,
  output logic      [31:0]       reg_rdata,
  output logic                   reg_bus_error,
  input  wire logic              osc_clk_in,
  output logic                   osc_enable,
  output logic [CR_LOAD_W-1:0]   osc_load_sel,
  output logic                   clk32_out_en,
  output logic                   rtc_irq,
  output logic                   seconds_irq,
  output logic                   wake_pin_o,
  output logic                   wake_pin_oe_n
);

  // ----------------------------------------------------------------
  // elaboration check
  // ----------------------------------------------------------------
  if (ADDR_W < 5) begin : g_addr_too_narrow
    $error("rtcl_core: ADDR_W must be at least 5");
  end

  // ----------------------------------------------------------------
  // state
  // ----------------------------------------------------------------
  logic [31:0]          tsr_q, tsr_d;
  logic [TPR_W-1:0]     tpr_q, tpr_d;
  logic [31:0]          tar_q, tar_d;
  logic [31:0]          tcr_q, tcr_d;
  logic [CR_LOAD_W-1:0] load_q, load_d;
  logic                 clko_q, clko_d;
  logic                 osce_q, osce_d;
  logic                 wps_q, wps_d;
  logic                 um_q, um_d;
  logic                 sup_q, sup_d;
  logic                 wpe_q, wpe_d;
  logic                 swr_q, swr_d;
  logic                 tce_q, tce_d;
  logic                 tif_q, tif_d;
  logic                 tof_q, tof_d;
  logic                 taf_q, taf_d;
  logic                 lrl_q, lrl_d;
  logic                 srl_q, srl_d;
  logic                 crl_q, crl_d;
  logic                 tcl_q, tcl_d;
  logic                 wake_pin_force_on_q, wake_pin_force_on_d;
  logic                 seconds_pulse_irq_en_q, seconds_pulse_irq_en_d;
  logic                 alarm_irq_en_q, alarm_irq_en_d;
  logic                 overflow_irq_en_q, overflow_irq_en_d;
  logic                 invalid_irq_en_q, invalid_irq_en_d;
  logic [31:0]          rdata_q, rdata_d;
  logic                 berr_q, berr_d;
  logic                 spulse_q, spulse_d;

  // ----------------------------------------------------------------
  // helpers
  // ----------------------------------------------------------------
  logic             osc_level;
  logic             osc_tick;
  logic             wr_ok;
  logic             run;
  logic [TPR_W-1:0] tpr_inc;
  logic             sec_step;
  logic             tce_writable;
  logic             time_zero;
  logic [31:0]      rd_mux;

  rtcl_osc_sync u_osc_sync (
    .clk_sys   (clk_sys),
    .resetn    (resetn),
    .osc_pin   (osc_clk_in),
    .osc_level (osc_level),
    .osc_tick  (osc_tick)
  );

  // ----------------------------------------------------------------
  // write permission and counter stepping
  // ----------------------------------------------------------------
  // user writes need the supervisor bit; reads are never checked
  assign wr_ok = reg_wr & (sup_q | reg_wr_supervisor);

  // clock present means the oscillator is enabled and an edge was seen
  assign run      = tce_q & !tif_q & !tof_q & osce_q & osc_tick;
  assign tpr_inc  = tpr_q + 1'b1;
  assign sec_step = run & tpr_q[TPR_SEC_BIT] & !tpr_inc[TPR_SEC_BIT];

  // counter enable access under the status lock
  always_comb begin
    tce_writable = srl_q;
    if (!srl_q && um_q) begin
      tce_writable = !tce_q | tif_q | tof_q;
    end
  end

  assign time_zero = tif_q | tof_q;

  // ----------------------------------------------------------------
  // read mux
  // ----------------------------------------------------------------
  always_comb begin
    rd_mux = 32'h00000000;
    if (reg_addr == ADDR_W'(OFS_TSR)) begin
      rd_mux = time_zero ? 32'h00000000 : tsr_q;
    end else if (reg_addr == ADDR_W'(OFS_TPR)) begin
      rd_mux[TPR_W-1:0] = time_zero ? {TPR_W{1'b0}} : tpr_q;
    end else if (reg_addr == ADDR_W'(OFS_TAR)) begin
      rd_mux = tar_q;
    end else if (reg_addr == ADDR_W'(OFS_TCR)) begin
      rd_mux = tcr_q;
    end else if (reg_addr == ADDR_W'(OFS_CR)) begin
      rd_mux[CR_LOAD_LSB +: CR_LOAD_W] = load_q;
      rd_mux[CR_CLKO] = clko_q;
      rd_mux[CR_OSCE] = osce_q;
      rd_mux[CR_WPS]  = wps_q;
      rd_mux[CR_UM]   = um_q;
      rd_mux[CR_SUP]  = sup_q;
      rd_mux[CR_WPE]  = wpe_q;
      rd_mux[CR_SWR]  = swr_q;
    end else if (reg_addr == ADDR_W'(OFS_SR)) begin
      rd_mux[SR_TCE] = tce_q;
      rd_mux[SR_TAF] = taf_q;
      rd_mux[SR_TOF] = tof_q;
      rd_mux[SR_TIF] = tif_q;
    end else if (reg_addr == ADDR_W'(OFS_LR)) begin
      rd_mux[LR_ONE7] = 1'b1;
      rd_mux[LR_LRL]  = lrl_q;
      rd_mux[LR_SRL]  = srl_q;
      rd_mux[LR_CRL]  = crl_q;
      rd_mux[LR_TCL]  = tcl_q;
      rd_mux[LR_ONES_W-1:0] = {LR_ONES_W{1'b1}};
    end else if (reg_addr == ADDR_W'(OFS_IER)) begin
      rd_mux[IER_WAKE_PIN_FORCE_ON] = wake_pin_force_on_q;
      rd_mux[IER_SECONDS_PULSE_IRQ_EN] = seconds_pulse_irq_en_q;
      rd_mux[IER_RSV3] = IER_RESET[IER_RSV3];
      rd_mux[IER_ALARM_IRQ_EN] = alarm_irq_en_q;
      rd_mux[IER_OVERFLOW_IRQ_EN] = overflow_irq_en_q;
      rd_mux[IER_INVALID_IRQ_EN] = invalid_irq_en_q;
    end
  end

  // ----------------------------------------------------------------
  // next state of every register
  // ----------------------------------------------------------------
  always_comb begin
    tsr_d    = tsr_q;
    tpr_d    = tpr_q;
    tar_d    = tar_q;
    tcr_d    = tcr_q;
    load_d   = load_q;
    clko_d   = clko_q;
    osce_d   = osce_q;
    wps_d    = wps_q;
    um_d     = um_q;
    sup_d    = sup_q;
    wpe_d    = wpe_q;
    swr_d    = swr_q;
    tce_d    = tce_q;
    tif_d    = tif_q;
    tof_d    = tof_q;
    taf_d    = taf_q;
    lrl_d    = lrl_q;
    srl_d    = srl_q;
    crl_d    = crl_q;
    tcl_d    = tcl_q;
    wake_pin_force_on_d   = wake_pin_force_on_q;
    seconds_pulse_irq_en_d   = seconds_pulse_irq_en_q;
    alarm_irq_en_d   = alarm_irq_en_q;
    overflow_irq_en_d   = overflow_irq_en_q;
    invalid_irq_en_d   = invalid_irq_en_q;
    spulse_d = 1'b0;
    // rejected user write answers one cycle later; locks never error
    berr_d   = reg_wr & !sup_q & !reg_wr_supervisor;
    rdata_d  = reg_rd ? rd_mux : 32'h00000000;

    // software writes; a locked target just drops the data
    if (wr_ok) begin
      if (reg_addr == ADDR_W'(OFS_TSR) && !tce_q) begin
        tsr_d = reg_wdata;
        tif_d = 1'b0;
        tof_d = 1'b0;
      end
      if (reg_addr == ADDR_W'(OFS_TPR) && !tce_q) begin
        tpr_d = reg_wdata[TPR_W-1:0];
      end
      if (reg_addr == ADDR_W'(OFS_TAR)) begin
        tar_d = reg_wdata;
        taf_d = 1'b0;
      end
      if (reg_addr == ADDR_W'(OFS_TCR) && tcl_q) begin
        tcr_d = reg_wdata;
      end
      if (reg_addr == ADDR_W'(OFS_CR) && crl_q) begin
        load_d = reg_wdata[CR_LOAD_LSB +: CR_LOAD_W];
        clko_d = reg_wdata[CR_CLKO];
        osce_d = reg_wdata[CR_OSCE];
        wps_d  = reg_wdata[CR_WPS];
        um_d   = reg_wdata[CR_UM];
        sup_d  = reg_wdata[CR_SUP];
        wpe_d  = reg_wdata[CR_WPE];
        swr_d  = reg_wdata[CR_SWR];
      end
      if (reg_addr == ADDR_W'(OFS_SR) && tce_writable) begin
        tce_d = reg_wdata[SR_TCE];
      end
      // lock bits only ever clear; a one written is ignored
      if (reg_addr == ADDR_W'(OFS_LR) && lrl_q) begin
        lrl_d = lrl_q & reg_wdata[LR_LRL];
        srl_d = srl_q & reg_wdata[LR_SRL];
        crl_d = crl_q & reg_wdata[LR_CRL];
        tcl_d = tcl_q & reg_wdata[LR_TCL];
      end
      if (reg_addr == ADDR_W'(OFS_IER)) begin
        wake_pin_force_on_d = reg_wdata[IER_WAKE_PIN_FORCE_ON];
        seconds_pulse_irq_en_d = reg_wdata[IER_SECONDS_PULSE_IRQ_EN];
        alarm_irq_en_d = reg_wdata[IER_ALARM_IRQ_EN];
        overflow_irq_en_d = reg_wdata[IER_OVERFLOW_IRQ_EN];
        invalid_irq_en_d = reg_wdata[IER_INVALID_IRQ_EN];
      end
    end

    // time counting; runs only with enable set, so never meets a TSR or TPR write; a same-cycle alarm hit beats a TAR write
    if (run) begin
      tpr_d = tpr_inc;
    end
    if (sec_step) begin
      tsr_d    = tsr_q + 1'b1;
      spulse_d = seconds_pulse_irq_en_q;
      if (tar_q == tsr_q) begin
        taf_d = 1'b1;
      end
      if (tsr_q == TSR_MAX) begin
        tof_d = 1'b1;
      end
    end

    // software reset holds everything but itself, the control lock and the read data and bus error answers
    if (swr_q) begin
      tsr_d    = 32'h00000000;
      tpr_d    = {TPR_W{1'b0}};
      tar_d    = 32'h00000000;
      tcr_d    = 32'h00000000;
      load_d   = {CR_LOAD_W{1'b0}};
      clko_d   = 1'b0;
      osce_d   = 1'b0;
      wps_d    = 1'b0;
      um_d     = 1'b0;
      sup_d    = 1'b0;
      wpe_d    = 1'b0;
      tce_d    = 1'b0;
      tif_d    = 1'b1;
      tof_d    = 1'b0;
      taf_d    = 1'b0;
      lrl_d    = LOCK_RESET;
      srl_d    = LOCK_RESET;
      tcl_d    = LOCK_RESET;
      wake_pin_force_on_d   = IER_RESET[IER_WAKE_PIN_FORCE_ON];
      seconds_pulse_irq_en_d   = IER_RESET[IER_SECONDS_PULSE_IRQ_EN];
      alarm_irq_en_d   = IER_RESET[IER_ALARM_IRQ_EN];
      overflow_irq_en_d   = IER_RESET[IER_OVERFLOW_IRQ_EN];
      invalid_irq_en_d   = IER_RESET[IER_INVALID_IRQ_EN];
      spulse_d = 1'b0;
    end
  end

  // ----------------------------------------------------------------
  // registers; power-on reset gives every default
  // ----------------------------------------------------------------
  always_ff @(posedge clk_sys or negedge resetn) begin
    if (!resetn) begin
      tsr_q    <= 32'h00000000;
      tpr_q    <= {TPR_W{1'b0}};
      tar_q    <= 32'h00000000;
      tcr_q    <= 32'h00000000;
      load_q   <= {CR_LOAD_W{1'b0}};
      clko_q   <= 1'b0;
      osce_q   <= 1'b0;
      wps_q    <= 1'b0;
      um_q     <= 1'b0;
      sup_q    <= 1'b0;
      wpe_q    <= 1'b0;
      swr_q    <= 1'b0;
      tce_q    <= 1'b0;
      tif_q    <= 1'b1;
      tof_q    <= 1'b0;
      taf_q    <= 1'b0;
      lrl_q    <= LOCK_RESET;
      srl_q    <= LOCK_RESET;
      crl_q    <= LOCK_RESET;
      tcl_q    <= LOCK_RESET;
      wake_pin_force_on_q   <= IER_RESET[IER_WAKE_PIN_FORCE_ON];
      seconds_pulse_irq_en_q   <= IER_RESET[IER_SECONDS_PULSE_IRQ_EN];
      alarm_irq_en_q   <= IER_RESET[IER_ALARM_IRQ_EN];
      overflow_irq_en_q   <= IER_RESET[IER_OVERFLOW_IRQ_EN];
      invalid_irq_en_q   <= IER_RESET[IER_INVALID_IRQ_EN];
      rdata_q  <= 32'h00000000;
      berr_q   <= 1'b0;
      spulse_q <= 1'b0;
    end else begin
      tsr_q    <= tsr_d;
      tpr_q    <= tpr_d;
      tar_q    <= tar_d;
      tcr_q    <= tcr_d;
      load_q   <= load_d;
      clko_q   <= clko_d;
      osce_q   <= osce_d;
      wps_q    <= wps_d;
      um_q     <= um_d;
      sup_q    <= sup_d;
      wpe_q    <= wpe_d;
      swr_q    <= swr_d;
      tce_q    <= tce_d;
      tif_q    <= tif_d;
      tof_q    <= tof_d;
      taf_q    <= taf_d;
      lrl_q    <= lrl_d;
      srl_q    <= srl_d;
      crl_q    <= crl_d;
      tcl_q    <= tcl_d;
      wake_pin_force_on_q   <= wake_pin_force_on_d;
      seconds_pulse_irq_en_q   <= seconds_pulse_irq_en_d;
      alarm_irq_en_q   <= alarm_irq_en_d;
      overflow_irq_en_q   <= overflow_irq_en_d;
      invalid_irq_en_q   <= invalid_irq_en_d;
      rdata_q  <= rdata_d;
      berr_q   <= berr_d;
      spulse_q <= spulse_d;
    end
  end

  // ----------------------------------------------------------------
  // outputs
  // ----------------------------------------------------------------
  // asserted straight out of reset: invalid flag and its enable are set
  assign rtc_irq = (taf_q & alarm_irq_en_q) | (tof_q & overflow_irq_en_q) | (tif_q & invalid_irq_en_q);

  assign seconds_irq   = spulse_q;
  assign reg_rdata     = rdata_q;
  assign reg_bus_error = berr_q;
  assign osc_enable    = osce_q;
  assign osc_load_sel  = load_q;
  assign clk32_out_en  = osce_q & !clko_q;

  // clock mode on the pin needs the clock routed out and force-on
  rtcl_wake_pin u_wake_pin (
    .clk_sys    (clk_sys),
    .resetn     (resetn),
    .pin_enable (wpe_q),
    .force_on   (wake_pin_force_on_q),
    .irq_level  (rtc_irq),
    .clk_mode   (wps_q & wake_pin_force_on_q & clk32_out_en),
    .osc_level  (osc_level),
    .pin_o      (wake_pin_o),
    .pin_oe_n   (wake_pin_oe_n)
  );

endmodule : rtcl_core
`default_nettype wire

// ===== testbench/rtcl_core_properties.sv
// checker: port-level properties of the rtc core
`timescale 1ns/100ps
`default_nettype none
module rtcl_core_properties
  import rtcl_pkg::*;
#(
  parameter int ADDR_W = 8
) (
  input wire logic              clk_sys,
  input wire logic              resetn,
  input wire logic [ADDR_W-1:0] reg_addr,
  input wire logic              reg_wr,
  input wire logic              reg_rd,
  input wire logic              reg_wr_supervisor,
  input wire logic [31:0]       reg_rdata,
  input wire logic              reg_bus_error,
  input wire logic              osc_enable,
  input wire logic              clk32_out_en,
  input wire logic              rtc_irq,
  input wire logic              seconds_irq,
  input wire logic              wake_pin_o
);
  default clocking @(posedge clk_sys); endclocking
  default disable iff (!resetn);

  // ----------------------------------------
  // register port answers
  // ----------------------------------------
  chk_rdata_idle: assert property (!reg_rd |=> reg_rdata == 32'h0)
    else $error("read data outside its slot");
  chk_lock_fixed_bits: assert property (reg_rd && reg_addr == ADDR_W'(OFS_LR) |=> reg_rdata[31:7] == 25'h1)
    else $error("lock register fixed bits wrong");
  chk_user_write_err: assert property (reg_bus_error |-> $past(reg_wr && !reg_wr_supervisor))
    else $error("bus error without a user write");
  chk_super_write_ok: assert property (reg_wr && reg_wr_supervisor |=> !reg_bus_error)
    else $error("supervisor write refused");
  chk_read_no_err: assert property (reg_rd |=> !reg_bus_error)
    else $error("bus error on a read");

  // ----------------------------------------
  // interrupts, oscillator and pin
  // ----------------------------------------
  // seconds pulses are a full second apart, so eight quiet cycles is safe
  chk_sec_pulse_once: assert property (seconds_irq |=> !seconds_irq [*8])
    else $error("seconds pulse too long");
  chk_reset_irq_on: assert property ($rose(resetn) |-> rtc_irq)
    else $error("interrupt low after reset");
  chk_reset_osc_off: assert property ($rose(resetn) |-> !osc_enable && !seconds_irq)
    else $error("oscillator on after reset");
  chk_clkout_gate: assert property (clk32_out_en |-> osc_enable)
    else $error("clock out without oscillator");
  chk_osc_sw_only: assert property ($rose(osc_enable) |-> $past(reg_wr && reg_addr == ADDR_W'(OFS_CR)))
    else $error("oscillator enabled without a control write");
  chk_wake_drive_low: assert property (wake_pin_o == 1'b0)
    else $error("wake pin driven high");
endmodule : rtcl_core_properties
`default_nettype wire

// ===== testbench/rtcl_core_tb_top.sv
// testbench: register-level checks of the rtc core
`timescale 1ns/100ps
`default_nettype none
module rtcl_core_tb_top
  import rtcl_pkg::*;
;
  localparam int ADDR_W = 8;
  logic              clk_sys = 1'b0;
  logic              resetn = 1'b0;
  logic [ADDR_W-1:0] reg_addr = '0;
  logic [31:0]       reg_wdata = '0;
  logic              reg_wr = 1'b0;
  logic              reg_rd = 1'b0;
  logic              reg_wr_supervisor = 1'b0;
  logic              osc_clk_in = 1'b0;
  logic [31:0]       reg_rdata;
  logic [CR_LOAD_W-1:0] osc_load_sel;
  logic              reg_bus_error, osc_enable, clk32_out_en, rtc_irq, seconds_irq, wake_pin_o, wake_pin_oe_n;
  logic              osc_run = 1'b0;
  logic [2:0]        osc_cnt = 3'h0;
  logic              rd_p = 1'b0;
  logic              wr_p = 1'b0;
  logic [31:0]       exp_q[$];
  logic              err_q[$];
  int                fails = 0;
  int                checks = 0;
  int                cyc = 0;

  rtcl_core #(.ADDR_W(ADDR_W)) u_rtcl_core (
    .clk_sys(clk_sys), .resetn(resetn), .reg_addr(reg_addr), .reg_wdata(reg_wdata),
    .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_wr_supervisor(reg_wr_supervisor),
    .reg_rdata(reg_rdata), .reg_bus_error(reg_bus_error), .osc_clk_in(osc_clk_in),
    .osc_enable(osc_enable), .osc_load_sel(osc_load_sel), .clk32_out_en(clk32_out_en), .rtc_irq(rtc_irq),
    .seconds_irq(seconds_irq), .wake_pin_o(wake_pin_o), .wake_pin_oe_n(wake_pin_oe_n)
  );

  // ----------------------------------------
  // clock, crystal stand-in and timeout
  // ----------------------------------------
  always #4 clk_sys = ~clk_sys;
  // crystal runs only while a second is wanted, much faster than real time
  always @(posedge clk_sys) begin
    if (osc_run) osc_cnt <= osc_cnt + 3'h1;
    osc_clk_in <= osc_cnt[2];
    cyc++;
    if (cyc == 5000) begin
      fails++;
      summarize();
    end
  end

  // ----------------------------------------
  // compare and report
  // ----------------------------------------
  task automatic cmp32(input logic [31:0] got, input logic [31:0] exp);
    checks++;
    if (got !== exp) begin
      fails++;
      $display("ERROR t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask : cmp32
  task automatic cmp1(input logic got, input logic exp);
    cmp32({31'h0, got}, {31'h0, exp});
  endtask : cmp1
  task automatic summarize();
    $display("checks=%0d fails=%0d", checks, fails);
    if (fails == 0 && checks > 0) begin
      $display("TEST PASSED");
    end else begin
      $display("TEST FAILED");
    end
    $finish;
  endtask : summarize
  // answers stand one cycle after the strobe, so pair them with the oldest note
  always @(posedge clk_sys) begin
    if (rd_p) cmp32(reg_rdata, exp_q.pop_front());
    if (wr_p) cmp1(reg_bus_error, err_q.pop_front());
    rd_p <= reg_rd;
    wr_p <= reg_wr;
  end

  // ----------------------------------------
  // bus cycles
  // ----------------------------------------
  task automatic wr(input logic [7:0] a, input logic [31:0] d, input logic s);
    @(posedge clk_sys);
    reg_addr <= a;
    reg_wdata <= d;
    reg_wr_supervisor <= s;
    reg_wr <= 1'b1;
    err_q.push_back(!s);
    @(posedge clk_sys);
    reg_wr <= 1'b0;
  endtask : wr
  task automatic rd(input logic [7:0] a, input logic [31:0] e);
    @(posedge clk_sys);
    reg_addr <= a;
    reg_rd <= 1'b1;
    exp_q.push_back(e);
    @(posedge clk_sys);
    reg_rd <= 1'b0;
  endtask : rd
  // load prescaler just below bit 14 falling, then let one second pass
  task automatic run_sec(input logic [31:0] s, input logic [31:0] a);
    int n;
    n = 0;
    wr(OFS_SR, 32'h0, 1'b1);
    wr(OFS_TPR, 32'h00007FFE, 1'b1);
    wr(OFS_TSR, s, 1'b1);
    wr(OFS_TAR, a, 1'b1);
    wr(OFS_IER, 32'h00000014, 1'b1);
    wr(OFS_SR, 32'h00000010, 1'b1);
    osc_run <= 1'b1;
    while (seconds_irq !== 1'b1 && n < 300) begin
      @(posedge clk_sys);
      #1;
      n++;
    end
    osc_run <= 1'b0;
    cmp1(seconds_irq, 1'b1);
  endtask : run_sec

  // ----------------------------------------
  // main sequence
  // ----------------------------------------
  initial begin
    logic [31:0] base;
    void'($urandom(32'h16DB0E86));
    repeat (10) @(posedge clk_sys);
    resetn <= 1'b1;
    rd(OFS_IER, 32'h0000000F);
    rd(OFS_LR, 32'h000000FF);
    rd(OFS_SR, 32'h00000001);
    rd(OFS_TSR, 32'h0);
    wr(OFS_IER, 32'h0, 1'b0);
    rd(OFS_IER, 32'h0000000F);
    // load caps are set while the oscillator is still off, then kept
    wr(OFS_CR, 32'h00003C00, 1'b1);
    wr(OFS_CR, 32'h00003D00, 1'b1);
    #1;
    cmp32(32'(osc_load_sel), 32'h0000000F);
    // alarm at a random time, then a refused counter write while running
    base = $urandom & 32'h7FFFFFFF;
    run_sec(base, base);
    wr(OFS_TSR, 32'h5, 1'b1);
    rd(OFS_SR, 32'h00000014);
    rd(OFS_TSR, base + 32'h1);
    rd(OFS_TSR, base + 32'h1);
    #1;
    cmp1(rtc_irq, 1'b1);
    wr(OFS_IER, 32'h00000010, 1'b1);
    #1;
    cmp1(rtc_irq, 1'b0);
    // wrap of the seconds counter
    run_sec(32'hFFFFFFFF, 32'h0);
    rd(OFS_SR, 32'h00000012);
    rd(OFS_TSR, 32'h0);
    rd(OFS_TPR, 32'h0);
    #1;
    cmp1(rtc_irq, 1'b0);
    wr(OFS_IER, 32'h00000012, 1'b1);
    #1;
    cmp1(rtc_irq, 1'b1);
    // wake pin forced on while interrupt is quiet
    wr(OFS_IER, 32'h00000010, 1'b1);
    wr(OFS_CR, 32'h00003D02, 1'b1);
    @(posedge clk_sys);
    #1;
    cmp1(wake_pin_oe_n, 1'b1);
    wr(OFS_IER, 32'h00000090, 1'b1);
    @(posedge clk_sys);
    #1;
    cmp1(wake_pin_oe_n, 1'b0);
    // lock and status locks
    wr(OFS_LR, 32'h0000009F, 1'b1);
    wr(OFS_SR, 32'h0, 1'b1);
    wr(OFS_LR, 32'h0, 1'b1);
    rd(OFS_LR, 32'h0000009F);
    rd(OFS_SR, 32'h00000012);
    // software reset restores flags and every lock but the control lock
    wr(OFS_CR, 32'h00003D01, 1'b1);
    rd(OFS_CR, 32'h00000001);
    // soft reset still holds in the clearing cycle, so only the bit itself lands
    wr(OFS_CR, 32'h00000000, 1'b1);
    cmp32(32'(osc_load_sel), 32'h00000000);
    rd(OFS_LR, 32'h000000FF);
    rd(OFS_SR, 32'h00000001);
    rd(OFS_IER, 32'h0000000F);
    // control and compensation locks, then an unmapped place
    wr(OFS_TCR, 32'h00000012, 1'b1);
    wr(OFS_LR, 32'h000000E7, 1'b1);
    wr(OFS_TCR, 32'h00000034, 1'b1);
    wr(OFS_CR, 32'h00000001, 1'b1);
    rd(OFS_TCR, 32'h00000012);
    rd(OFS_CR, 32'h00000000);
    rd(8'h40, 32'h0);
    wr(8'h40, 32'h1, 1'b1);
    repeat (3) @(posedge clk_sys);
    summarize();
  end
endmodule : rtcl_core_tb_top

bind rtcl_core rtcl_core_properties #(.ADDR_W(ADDR_W)) u_rtcl_core_properties (
  .clk_sys(clk_sys), .resetn(resetn), .reg_addr(reg_addr), .reg_wr(reg_wr), .reg_rd(reg_rd),
  .reg_wr_supervisor(reg_wr_supervisor), .reg_rdata(reg_rdata), .reg_bus_error(reg_bus_error),
  .osc_enable(osc_enable), .clk32_out_en(clk32_out_en), .rtc_irq(rtc_irq),
  .seconds_irq(seconds_irq), .wake_pin_o(wake_pin_o)
);
`default_nettype wire
